// ==== fscr_host_model.sv ====
// Host side model that issues decoded status register commands
`timescale 1ns/1ns
module fscr_host_model #(
   parameter bit PINS_TIED = 1'b0 // Protect and pause pins strapped to a rail
) (
   output logic cmd_valid, // Command strobe
   output fscr_pkg::fscr_cmd_t cmd_code, // Decoded command
   output logic [7:0] cmd_data, // Status write byte
   output logic [fscr_pkg::ADDR_W-1:0] cmd_start_addr, // Target first byte
   output logic [fscr_pkg::ADDR_W-1:0] cmd_end_addr // Target last byte
);
   import fscr_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = CMD_READ;
      cmd_data = 8'h00;
      cmd_start_addr = ADDR_ZERO;
      cmd_end_addr = ADDR_ZERO;
   end
   // quad enable withheld on strapped pins
   task automatic send(fscr_cmd_t c, logic [7:0] d, logic [ADDR_W-1:0] s, logic [ADDR_W-1:0] e);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_data = (PINS_TIED && c == CMD_WRSR2) ? (d & 8'hFD) : d;
      cmd_start_addr = s;
      cmd_end_addr = e;
   endtask
   // Data and address lines flip so a stale byte never passes as fresh
   task automatic release_bus();
      cmd_valid = 1'b0;
      cmd_data = ~cmd_data;
      cmd_start_addr = ~cmd_start_addr;
      cmd_end_addr = ~cmd_end_addr;
   endtask
endmodule

// ==== fscr_pkg.sv ====
// Constants, field layout and command codes of the flash status registers
package fscr_pkg;
   // Clock rate and operation times
   localparam int CLK_MHZ = 100;
   localparam int T_PROG_US = 2000;
   localparam int T_ERASE_US = 8000;
   localparam int T_WRSR_US = 5000;
   localparam int T_RST_US = 300;
   localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;
   localparam int ERASE_CYCLES = T_ERASE_US * CLK_MHZ;
   localparam int WRSR_CYCLES = T_WRSR_US * CLK_MHZ;
   localparam int RST_CYCLES = T_RST_US * CLK_MHZ;
   localparam int TMR_W = 32;
   localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
   localparam logic [TMR_W-1:0] TMR_ONE = 32'h0000_0001;

   // Array geometry
   localparam int ADDR_W = 19;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h0_0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 19'h0_0001;
   localparam logic [ADDR_W-1:0] ARRAY_TOP = 19'h7_FFFF;
   localparam logic [ADDR_W-1:0] SPAN_4K = 19'h0_0FFF;
   localparam logic [ADDR_W-1:0] SPAN_8K = 19'h0_1FFF;
   localparam logic [ADDR_W-1:0] SPAN_16K = 19'h0_3FFF;
   localparam logic [ADDR_W-1:0] SPAN_32K = 19'h0_7FFF;
   localparam logic [ADDR_W-1:0] SPAN_64K = 19'h0_FFFF;
   localparam logic [ADDR_W-1:0] SPAN_128K = 19'h1_FFFF;
   localparam logic [ADDR_W-1:0] SPAN_256K = 19'h3_FFFF;

   // Field positions, primary status
   localparam int SR1_LOCK_LO_BIT = 7;
   localparam int SR1_BP_HI = 6;
   localparam int SR1_BP_LO = 2;
   localparam int SR1_WEL_BIT = 1;
   localparam int SR1_BUSY_BIT = 0;
   // Field positions, secondary status
   localparam int SR2_SUS_BIT = 7;
   localparam int SR2_CMP_BIT = 6;
   localparam int SR2_LB_HI = 5;
   localparam int SR2_LB_LO = 3;
   localparam int SR2_RSVD_BIT = 2;
   localparam int SR2_QE_BIT = 1;
   localparam int SR2_LOCK_HI_BIT = 0;

   // Reset values of the stored fields, and the low protect-bit patterns
   localparam logic [4:0] BP_RESET = 5'h00;
   localparam logic [2:0] LB_RESET = 3'h0;
   localparam logic [2:0] BP_LOW_ZERO = 3'h0;
   localparam logic [2:0] BP_LOW_ONES = 3'h7;

   // Status lock select encodings {hi, lo}
   localparam logic [1:0] LOCK_SOFT = 2'h0;
   localparam logic [1:0] LOCK_PIN = 2'h1;
   localparam logic [1:0] LOCK_POWER = 2'h2;
   localparam logic [1:0] LOCK_FOREVER = 2'h3;

   typedef enum logic [3:0] {
      CMD_WREN, CMD_WRDI, CMD_WRSR1, CMD_WRSR2, CMD_PROG, CMD_ERASE, CMD_CHIP_ERASE,
      CMD_SUSPEND, CMD_RESUME, CMD_RST_EN, CMD_RST, CMD_READ, CMD_QUAD_READ, CMD_READ_STATUS
   } fscr_cmd_t;
endpackage

// ==== fscr_prot_decode.sv ====
// Protected-region decoder and target overlap check
`timescale 1ns/1ns
module fscr_prot_decode (
   fscr_prot_if.decoder bus // Protect settings in, overlap out
);
   import fscr_pkg::*;

   wire [2:0] bp_low = bus.bp[2:0];
   wire small_steps = bus.bp[4];
   wire from_top = !bus.bp[3];
   wire base_none = bp_low == BP_LOW_ZERO;
   wire base_all = small_steps ? (bp_low == BP_LOW_ONES) : bus.bp[2];
   wire [ADDR_W-1:0] span_small = (bp_low == 3'h1) ? SPAN_4K :
                                  (bp_low == 3'h2) ? SPAN_8K :
                                  (bp_low == 3'h3) ? SPAN_16K : SPAN_32K;
   wire [ADDR_W-1:0] span_big = (bus.bp[1:0] == 2'h1) ? SPAN_64K :
                                (bus.bp[1:0] == 2'h2) ? SPAN_128K : SPAN_256K;
   wire [ADDR_W-1:0] span = small_steps ? span_small : span_big;
   wire [ADDR_W-1:0] top_base = ARRAY_TOP - span;

   // Complement turns the block into the rest of the array
   wire reg_none = bus.cmp ? base_all : (base_none && !base_all);
   wire reg_all = bus.cmp ? base_none : base_all;
   wire [ADDR_W-1:0] part_lo = bus.cmp ? (from_top ? ADDR_ZERO : span + ADDR_ONE) :
                               (from_top ? top_base : ADDR_ZERO);
   wire [ADDR_W-1:0] part_hi = bus.cmp ? (from_top ? top_base - ADDR_ONE : ARRAY_TOP) :
                               (from_top ? ARRAY_TOP : span);
   wire [ADDR_W-1:0] reg_lo = reg_all ? ADDR_ZERO : part_lo;
   wire [ADDR_W-1:0] reg_hi = reg_all ? ARRAY_TOP : part_hi;

   assign bus.hit = !reg_none && (bus.start_addr <= reg_hi) && (bus.end_addr >= reg_lo);
endmodule

// ==== fscr_prot_if.sv ====
// Carrier between the register bank and its protection decoder
`timescale 1ns/1ns
interface fscr_prot_if;
   logic [4:0] bp;
   logic cmp;
   logic [fscr_pkg::ADDR_W-1:0] start_addr;
   logic [fscr_pkg::ADDR_W-1:0] end_addr;
   logic hit;
   modport owner (output bp, cmp, start_addr, end_addr, input hit);
   modport decoder (input bp, cmp, start_addr, end_addr, output hit);
endinterface

// ==== fscr_status_regs.sv ====
// Status and configuration register bank of a serial flash
// Operation
// - Lock select low bit, status1 bit 7
// - Five block-protect bits, status1 bits 6:2
// - Block-protect changes only by status write
// - Hardware protected mode refuses block-protect changes
// - Chip erase only with matching complement pattern
// - Write latch at bit 1 gates writes
// - Busy bit 0 high during operations
// - Suspend sets status2 bit 7
// - Resume, reset pair, power cycle clear suspend
// - Complement bit status2 bit 6 shapes region
// - Three lock bits, status2 5:3, settable
// - Set lock bits never clear
// - Quad-enable bit 1 repurposes protect pins
// - Lock select high bit, status2 bit 0
// - Decode lock select with protect pin
// - Refuse program/erase over protected region
// - Four-lane reads need quad-enable set
`timescale 1ns/1ns
module fscr_status_regs #(
   parameter int unsigned PROG_CYCLES = fscr_pkg::PROG_CYCLES, // Page program length
   parameter int unsigned ERASE_CYCLES = fscr_pkg::ERASE_CYCLES, // Erase length
   parameter int unsigned WRSR_CYCLES = fscr_pkg::WRSR_CYCLES, // Status write length
   parameter int unsigned RST_CYCLES = fscr_pkg::RST_CYCLES // Software reset recovery
) (
   input logic ref_clk, // System clock
   input logic reset_n, // Synchronous reset, active low
   input logic cmd_valid, // Decoded command strobe
   input fscr_pkg::fscr_cmd_t cmd_code, // Decoded command
   input logic [7:0] cmd_data, // Status write data byte
   input logic [fscr_pkg::ADDR_W-1:0] cmd_start_addr, // Target first byte
   input logic [fscr_pkg::ADDR_W-1:0] cmd_end_addr, // Target last byte
   input logic write_protect_n, // Protect pin level, low asserts
   input logic power_cycle, // Power-down/up event pulse
   output logic cmd_accept, // Command taken
   output logic cmd_reject, // Command refused
   output logic [7:0] primary_status_protect, // Status byte one
   output logic [7:0] secondary_status_config, // Status byte two
   output logic operation_in_progress, // Busy level
   output logic four_lane_enable, // Protect/pause pins act as data
   output logic [2:0] security_lock_bits // Security register locks
);
   import fscr_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SUSPENDED, ST_RESETTING} fscr_state_t;

   fscr_state_t state_ff;
   fscr_state_t nxt_state;
   logic [TMR_W-1:0] timer_ff;
   logic [TMR_W-1:0] nxt_timer;
   logic lock_lo_ff;
   logic lock_hi_ff;
   logic [4:0] bp_ff;
   logic cmp_ff;
   logic [2:0] lb_ff;
   logic qe_ff;
   logic wel_ff;
   logic busy_ff;
   logic sus_ff;
   logic wrsr_op_ff;
   logic rst_armed_ff;
   logic nxt_lock_lo;
   logic nxt_lock_hi;
   logic [4:0] nxt_bp;
   logic nxt_cmp;
   logic [2:0] nxt_lb;
   logic nxt_qe;
   logic nxt_wel;
   logic nxt_sus;
   logic nxt_wrsr_op;
   logic nxt_rst_armed;

   fscr_prot_if prot_bus ();

   assign prot_bus.bp = bp_ff;
   assign prot_bus.cmp = cmp_ff;
   assign prot_bus.start_addr = cmd_start_addr;
   assign prot_bus.end_addr = cmd_end_addr;

   fscr_prot_decode u_decode (
      .bus (prot_bus)
   );

   // Command decode
   wire is_wren = cmd_valid && cmd_code == CMD_WREN;
   wire is_wrdi = cmd_valid && cmd_code == CMD_WRDI;
   wire is_wrsr1 = cmd_valid && cmd_code == CMD_WRSR1;
   wire is_wrsr2 = cmd_valid && cmd_code == CMD_WRSR2;
   wire is_prog = cmd_valid && cmd_code == CMD_PROG;
   wire is_erase = cmd_valid && cmd_code == CMD_ERASE;
   wire is_chip = cmd_valid && cmd_code == CMD_CHIP_ERASE;
   wire is_suspend = cmd_valid && cmd_code == CMD_SUSPEND;
   wire is_resume = cmd_valid && cmd_code == CMD_RESUME;
   wire is_rst_en = cmd_valid && cmd_code == CMD_RST_EN;
   wire is_rst = cmd_valid && cmd_code == CMD_RST;
   wire is_read = cmd_valid && cmd_code == CMD_READ;
   wire is_quad = cmd_valid && cmd_code == CMD_QUAD_READ;
   wire is_rdsr = cmd_valid && cmd_code == CMD_READ_STATUS;

   wire idle = state_ff == ST_IDLE;
   wire quiet = idle || state_ff == ST_SUSPENDED;
   wire resetting = state_ff == ST_RESETTING;
   wire timer_done = timer_ff == TMR_ZERO;

   // protect pin is a data lane in quad mode
   wire pin_protects = !qe_ff && !write_protect_n;
   wire [1:0] lock_sel = {lock_hi_ff, lock_lo_ff};
   wire status_locked = (lock_sel == LOCK_PIN && pin_protects) ||
                        lock_sel == LOCK_POWER || lock_sel == LOCK_FOREVER;
   wire chip_ok = (bp_ff[2:0] == BP_LOW_ZERO && !cmp_ff) ||
                  (bp_ff[2:0] == BP_LOW_ONES && cmp_ff);

   wire ok_wrsr = idle && wel_ff && !status_locked;
   wire ok_array = idle && wel_ff && !prot_bus.hit;
   wire ok_quad = quiet && qe_ff;
   // Suspend only a running array operation with time left
   wire ok_suspend = state_ff == ST_BUSY && !wrsr_op_ff && !timer_done;

   wire acc_wren = is_wren && quiet;
   wire acc_wrdi = is_wrdi && quiet;
   wire acc_wrsr1 = is_wrsr1 && ok_wrsr;
   wire acc_wrsr2 = is_wrsr2 && ok_wrsr;
   wire acc_prog = is_prog && ok_array;
   wire acc_erase = is_erase && ok_array;
   wire acc_chip = is_chip && idle && wel_ff && chip_ok;
   wire acc_suspend = is_suspend && ok_suspend;
   wire acc_resume = is_resume && state_ff == ST_SUSPENDED;
   wire acc_rst_en = is_rst_en && !resetting;
   wire acc_rst = is_rst && rst_armed_ff && !resetting;
   wire acc_read = is_read && quiet;
   wire acc_quad = is_quad && ok_quad;
   wire acc_rdsr = is_rdsr && !resetting;
   wire acc_wrsr = acc_wrsr1 || acc_wrsr2;
   wire acc_start = acc_wrsr || acc_prog || acc_erase || acc_chip;

   // Power cycle overrides any command in the same cycle
   wire any_ok = acc_wren || acc_wrdi || acc_wrsr || acc_prog || acc_erase || acc_chip ||
                 acc_suspend || acc_resume || acc_rst_en || acc_rst || acc_read ||
                 acc_quad || acc_rdsr;
   assign cmd_accept = any_ok && !power_cycle;
   assign cmd_reject = cmd_valid && !cmd_accept;

   wire go_wrsr = acc_wrsr && !power_cycle;
   wire go_start = acc_start && !power_cycle;
   wire go_rst = acc_rst && !power_cycle;
   wire go_suspend = acc_suspend && !power_cycle;
   wire go_resume = acc_resume && !power_cycle;
   wire op_done = state_ff == ST_BUSY && timer_done;
   wire rst_done = resetting && timer_done;

   // Sequencer
   assign nxt_state = power_cycle ? ST_IDLE :
                      go_rst ? ST_RESETTING :
                      go_start ? ST_BUSY :
                      go_suspend ? ST_SUSPENDED :
                      go_resume ? ST_BUSY :
                      (op_done || rst_done) ? ST_IDLE : state_ff;

   wire counting = (state_ff == ST_BUSY || resetting) && !timer_done;
   assign nxt_timer = power_cycle ? TMR_ZERO :
                      go_rst ? TMR_W'(RST_CYCLES - 1) :
                      (go_start && acc_prog) ? TMR_W'(PROG_CYCLES - 1) :
                      (go_start && acc_wrsr) ? TMR_W'(WRSR_CYCLES - 1) :
                      go_start ? TMR_W'(ERASE_CYCLES - 1) :
                      counting && !go_suspend ? timer_ff - TMR_ONE : timer_ff;

   assign nxt_wrsr_op = go_start ? acc_wrsr : wrsr_op_ff;

   assign nxt_wel = (power_cycle || go_rst || op_done) ? 1'b0 :
                    (acc_wrdi) ? 1'b0 :
                    acc_wren ? 1'b1 : wel_ff;

   // resume, reset or power cycle clear it
   assign nxt_sus = (power_cycle || go_rst || go_resume) ? 1'b0 :
                    go_suspend ? 1'b1 : sus_ff;

   // Reset needs the enable as the immediately preceding command
   assign nxt_rst_armed = power_cycle ? 1'b0 :
                          cmd_valid ? (acc_rst_en && !power_cycle) : rst_armed_ff;

   // power lock-down returns to software mode on power cycle
   wire power_release = power_cycle && lock_sel == LOCK_POWER;
   assign nxt_lock_lo = power_release ? 1'b0 :
                        (go_wrsr && acc_wrsr1) ? cmd_data[SR1_LOCK_LO_BIT] : lock_lo_ff;
   assign nxt_lock_hi = power_release ? 1'b0 :
                        (go_wrsr && acc_wrsr2) ? cmd_data[SR2_LOCK_HI_BIT] : lock_hi_ff;
   // only the status write updates it
   assign nxt_bp = (go_wrsr && acc_wrsr1) ? cmd_data[SR1_BP_HI:SR1_BP_LO] : bp_ff;
   assign nxt_cmp = (go_wrsr && acc_wrsr2) ? cmd_data[SR2_CMP_BIT] : cmp_ff;
   assign nxt_lb = (go_wrsr && acc_wrsr2) ? (lb_ff | cmd_data[SR2_LB_HI:SR2_LB_LO]) : lb_ff;
   assign nxt_qe = (go_wrsr && acc_wrsr2) ? cmd_data[SR2_QE_BIT] : qe_ff;

   // Stored fields model factory defaults on reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lock_lo_ff <= 1'b0;
         lock_hi_ff <= 1'b0;
         bp_ff <= BP_RESET;
         cmp_ff <= 1'b0;
         lb_ff <= LB_RESET;
         qe_ff <= 1'b0;
      end else begin
         lock_lo_ff <= nxt_lock_lo;
         lock_hi_ff <= nxt_lock_hi;
         bp_ff <= nxt_bp;
         cmp_ff <= nxt_cmp;
         lb_ff <= nxt_lb;
         qe_ff <= nxt_qe;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         timer_ff <= TMR_ZERO;
         wrsr_op_ff <= 1'b0;
         rst_armed_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         wrsr_op_ff <= nxt_wrsr_op;
         rst_armed_ff <= nxt_rst_armed;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wel_ff <= 1'b0;
         busy_ff <= 1'b0;
         sus_ff <= 1'b0;
      end else begin
         wel_ff <= nxt_wel;
         busy_ff <= nxt_state == ST_BUSY;
         sus_ff <= nxt_sus;
      end
   end

   assign primary_status_protect[SR1_LOCK_LO_BIT] = lock_lo_ff;
   assign primary_status_protect[SR1_BP_HI:SR1_BP_LO] = bp_ff;
   assign primary_status_protect[SR1_WEL_BIT] = wel_ff;
   assign primary_status_protect[SR1_BUSY_BIT] = busy_ff;
   assign secondary_status_config[SR2_SUS_BIT] = sus_ff;
   assign secondary_status_config[SR2_CMP_BIT] = cmp_ff;
   assign secondary_status_config[SR2_LB_HI:SR2_LB_LO] = lb_ff;
   assign secondary_status_config[SR2_RSVD_BIT] = 1'b0;
   assign secondary_status_config[SR2_QE_BIT] = qe_ff;
   assign secondary_status_config[SR2_LOCK_HI_BIT] = lock_hi_ff;
   assign operation_in_progress = busy_ff;
   assign four_lane_enable = qe_ff;
   assign security_lock_bits = lb_ff;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   property p_wsr_locked;
      (is_wrsr1 || is_wrsr2) && status_locked |-> cmd_reject;
   endproperty
   a_wsr_locked: assert property (p_wsr_locked) else $error("Locked status write taken");

   property p_bp_hw_hold;
      lock_sel == LOCK_PIN && pin_protects |=> $stable(bp_ff);
   endproperty
   a_bp_hw_hold: assert property (p_bp_hw_hold) else $error("Protect bits changed under pin lock");

   property p_bp_only_wrsr;
      !(is_wrsr1 && cmd_accept) |=> $stable(bp_ff);
   endproperty
   a_bp_only_wrsr: assert property (p_bp_only_wrsr) else $error("Protect bits changed without write");

   property p_chip_gate;
      is_chip && cmd_accept |-> ((bp_ff[2:0] == BP_LOW_ZERO && !cmp_ff) || (bp_ff[2:0] == BP_LOW_ONES && cmp_ff));
   endproperty
   a_chip_gate: assert property (p_chip_gate) else $error("Chip erase taken with protection");

   property p_wel_gate;
      (is_wrsr1 || is_wrsr2 || is_prog || is_erase || is_chip) && !wel_ff |-> cmd_reject;
   endproperty
   a_wel_gate: assert property (p_wel_gate) else $error("Write taken without latch");

   property p_busy_start;
      (is_wrsr1 || is_wrsr2) && cmd_accept |=> operation_in_progress ##1 (operation_in_progress || $past(power_cycle));
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("Busy missing after status write");

   property p_sus_set;
      is_suspend && cmd_accept |=> secondary_status_config[SR2_SUS_BIT] && !operation_in_progress;
   endproperty
   a_sus_set: assert property (p_sus_set) else $error("Suspend flag not set");

   property p_sus_clear;
      (is_resume || is_rst) && cmd_accept || power_cycle |=> !secondary_status_config[SR2_SUS_BIT];
   endproperty
   a_sus_clear: assert property (p_sus_clear) else $error("Suspend flag not cleared");

   property p_lb_sticky;
      ##1 1'b1 |-> ((lb_ff & $past(lb_ff)) == $past(lb_ff));
   endproperty
   a_lb_sticky: assert property (p_lb_sticky) else $error("Lock bit cleared");

   property p_region_gate;
      (is_prog || is_erase) && prot_bus.hit |-> cmd_reject;
   endproperty
   a_region_gate: assert property (p_region_gate) else $error("Protected target accepted");

   property p_quad_gate;
      is_quad && !qe_ff |-> cmd_reject;
   endproperty
   a_quad_gate: assert property (p_quad_gate) else $error("Quad read without quad enable");

   property p_wel_done;
      op_done && !power_cycle |=> !primary_status_protect[SR1_WEL_BIT] && !operation_in_progress;
   endproperty
   a_wel_done: assert property (p_wel_done) else $error("Latch survived completion");
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the flash status register bank
`timescale 1ns/1ns
module tb_top;
   import fscr_pkg::*;
   localparam int PW = 8;
   localparam int EW = 10;
   localparam int WW = 6;
   localparam int RW = 5;
   typedef struct {int bp, cmp, lb, qe, slo, shi, write_enable_latch, bcnt, rcnt, paused_operation_flag, arm, kind;} fscr_ref_t;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic write_protect_n = 1'b1;
   logic power_cycle = 1'b0;
   logic pc_req = 1'b0;
   logic run_req = 1'b0;
   logic wp_req = 1'b1;
   logic cmd_valid, cmd_accept, cmd_reject, operation_in_progress, four_lane_enable;
   fscr_cmd_t cmd_code;
   logic [7:0] cmd_data, primary_status_protect, secondary_status_config;
   logic [ADDR_W-1:0] cmd_start_addr, cmd_end_addr, sa, ea;
   logic [2:0] security_lock_bits;
   logic [15:0] lfsr_q = 16'h6DEC;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   bit ok_q;
   fscr_ref_t m;
   always #5 ref_clk = ~ref_clk;
   fscr_host_model host (.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .cmd_start_addr(cmd_start_addr), .cmd_end_addr(cmd_end_addr));
   fscr_status_regs #(.PROG_CYCLES(PW), .ERASE_CYCLES(EW), .WRSR_CYCLES(WW), .RST_CYCLES(RW)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .cmd_start_addr(cmd_start_addr), .cmd_end_addr(cmd_end_addr),
      .write_protect_n(write_protect_n), .power_cycle(power_cycle), .cmd_accept(cmd_accept),
      .cmd_reject(cmd_reject), .primary_status_protect(primary_status_protect),
      .secondary_status_config(secondary_status_config), .operation_in_progress(operation_in_progress),
      .four_lane_enable(four_lane_enable), .security_lock_bits(security_lock_bits));
   function automatic logic [15:0] lfsr_next(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Reduced protect map: only the settings this bench programs
   function automatic bit ovl(logic [ADDR_W-1:0] e);
      if (m.cmp == 0 && m.bp == 0) return 1'b0;
      if (m.cmp == 0 && m.bp == 1) return e >= 19'h7_0000;
      return 1'b1;
   endfunction
   function automatic bit acc(fscr_cmd_t c, logic [ADDR_W-1:0] e);
      bit fr;
      bit lk;
      fr = m.bcnt == 0 && m.paused_operation_flag == 0 && m.write_enable_latch == 1;
      lk = m.shi == 1 || (m.slo == 1 && write_protect_n == 1'b0 && m.qe == 0);
      if (power_cycle || m.rcnt != 0) return 1'b0;
      case (c)
         CMD_WREN, CMD_WRDI, CMD_READ: return m.bcnt == 0 || m.paused_operation_flag == 1;
         CMD_WRSR1, CMD_WRSR2: return fr && !lk;
         CMD_PROG, CMD_ERASE: return fr && !ovl(e);
         CMD_CHIP_ERASE: return fr && ((m.bp % 8 == 0 && m.cmp == 0) || (m.bp % 8 == 7 && m.cmp == 1));
         CMD_SUSPEND: return m.bcnt > 1 && m.paused_operation_flag == 0 && m.kind == 1;
         CMD_RESUME: return m.paused_operation_flag == 1;
         CMD_RST: return m.arm == 1;
         CMD_QUAD_READ: return m.qe == 1 && (m.bcnt == 0 || m.paused_operation_flag == 1);
         default: return 1'b1;
      endcase
   endfunction
   always @(posedge ref_clk) begin
      cycles++;
      // Hang guard, run needs well under this
      if (cycles == 3000) begin
         failures++;
         test_done();
      end
      ok_q = cmd_valid && acc(cmd_code, cmd_end_addr);
      if (!reset_n) begin
         m = '{default: 0};
      end else if (power_cycle) begin
         m.write_enable_latch = 0;
         m.bcnt = 0;
         m.rcnt = 0;
         m.paused_operation_flag = 0;
         m.arm = 0;
         if (m.shi == 1 && m.slo == 0) m.shi = 0;
      end else begin
         if (m.rcnt != 0) m.rcnt--;
         // Timer freezes in the cycle the suspend is taken
         if (m.bcnt != 0 && m.paused_operation_flag == 0 && !(ok_q && cmd_code == CMD_SUSPEND)) begin
            m.bcnt--;
            if (m.bcnt == 0) m.write_enable_latch = 0;
         end
         if (ok_q) begin
            case (cmd_code)
               CMD_WREN: m.write_enable_latch = 1;
               CMD_WRDI: m.write_enable_latch = 0;
               CMD_WRSR1: begin
                  m.slo = cmd_data[7];
                  m.bp = cmd_data[6:2];
                  m.bcnt = WW;
                  m.kind = 0;
               end
               CMD_WRSR2: begin
                  m.cmp = cmd_data[6];
                  m.lb = m.lb | cmd_data[5:3];
                  m.qe = cmd_data[1];
                  m.shi = cmd_data[0];
                  m.bcnt = WW;
                  m.kind = 0;
               end
               CMD_PROG, CMD_ERASE, CMD_CHIP_ERASE: begin
                  m.bcnt = cmd_code == CMD_PROG ? PW : EW;
                  m.kind = 1;
               end
               CMD_SUSPEND: m.paused_operation_flag = 1;
               CMD_RESUME: m.paused_operation_flag = 0;
               CMD_RST: begin
                  m.rcnt = RW;
                  m.paused_operation_flag = 0;
                  m.write_enable_latch = 0;
                  m.bcnt = 0;
               end
               default: ;
            endcase
         end
         if (cmd_valid) m.arm = ok_q && cmd_code == CMD_RST_EN;
      end
   end
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, model %h", $time, seen, exp);
      end
   endtask
   task automatic step(bit v, fscr_cmd_t c = CMD_READ, logic [7:0] d = 8'h00, logic [ADDR_W-1:0] s = ADDR_ZERO,
      logic [ADDR_W-1:0] e = ADDR_ZERO);
      bit ok;
      bit b;
      @(posedge ref_clk);
      #1;
      power_cycle = pc_req;
      pc_req = 1'b0;
      reset_n = run_req;
      write_protect_n = wp_req;
      if (v) host.send(c, d, s, e);
      else host.release_bus();
      #1;
      ok = v && acc(c, e);
      b = m.bcnt != 0 && m.paused_operation_flag == 0;
      chk({6'h00, cmd_accept, cmd_reject}, {6'h00, ok, v && !ok});
      chk(primary_status_protect, {m.slo[0], m.bp[4:0], m.write_enable_latch[0], b});
      chk(secondary_status_config, {m.paused_operation_flag[0], m.cmp[0], m.lb[2:0], 1'b0, m.qe[0], m.shi[0]});
      chk({operation_in_progress, four_lane_enable, security_lock_bits, 3'h0}, {b, m.qe[0], m.lb[2:0], 3'h0});
   endtask
   task automatic wait_cyc(int n);
      repeat (n) step(1'b0);
   endtask
   task automatic test_done();
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      m = '{default: 0};
      wait_cyc(1);
      run_req = 1'b1;
      wait_cyc(1);
      step(1'b1, CMD_WRSR1, 8'h1C);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR1, 8'h1C);
      step(1'b1, CMD_READ_STATUS);
      step(1'b1, CMD_READ);
      step(1'b1, CMD_WRDI);
      wait_cyc(WW - 2);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_CHIP_ERASE);
      step(1'b1, CMD_WRSR2, 8'hCA);
      wait_cyc(WW + 1);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_CHIP_ERASE);
      wait_cyc(3);
      step(1'b1, CMD_SUSPEND);
      step(1'b1, CMD_QUAD_READ);
      step(1'b1, CMD_WRDI);
      step(1'b1, CMD_WRSR1, 8'h00);
      step(1'b1, CMD_RESUME);
      step(1'b1, CMD_RESUME);
      wait_cyc(EW);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR2, 8'h00);
      wait_cyc(WW + 1);
      step(1'b1, CMD_QUAD_READ);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR1, 8'h84);
      wait_cyc(WW + 1);
      wp_req = 1'b0;
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR1, 8'h00);
      wp_req = 1'b1;
      step(1'b1, CMD_WRSR1, 8'h04);
      wait_cyc(WW + 1);
      // Edge of the protected upper eighth, then random targets
      for (int i = 0; i < 6; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         sa = i < 2 ? 19'h6_FF00 + i : {i[0] ? 3'h7 : 3'h1, lfsr_q[15:8], 8'h00};
         ea = sa + 19'h0_00FF;
         step(1'b1, CMD_WREN);
         step(1'b1, i[1] ? CMD_ERASE : CMD_PROG, 8'h00, sa, ea);
         wait_cyc(EW + 1);
      end
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR2, 8'h31);
      wait_cyc(WW + 1);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR1, 8'h00);
      pc_req = 1'b1;
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_WRSR2, 8'h00);
      wait_cyc(WW + 1);
      step(1'b1, CMD_RST);
      step(1'b1, CMD_WREN);
      step(1'b1, CMD_PROG, 8'h00, 19'h1_0000, 19'h1_00FF);
      wait_cyc(2);
      step(1'b1, CMD_SUSPEND);
      step(1'b1, CMD_RST_EN);
      step(1'b1, CMD_RST);
      step(1'b1, CMD_WREN);
      wait_cyc(RW);
      step(1'b1, CMD_WREN);
      test_done();
   end
endmodule
